// File: pkg/fcl_cfg.svh
/*
 * Constants of the frequency command limiter: register offsets, reset
 * values, setting ranges and special codes.
 * Assumes frequencies in 0.1 Hz steps and voltages in 1 V steps.
 */
`ifndef FCL_CFG_SVH
`define FCL_CFG_SVH

// ---------------------------------------------------------------
// bus widths
// ---------------------------------------------------------------
`define FCL_AW 4
`define FCL_DW 16

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define FCL_OFS_UPPER  4'h0
`define FCL_OFS_LOWER  4'h1
`define FCL_OFS_HSUP   4'h2
`define FCL_OFS_STARTF 4'h3
`define FCL_OFS_JOGF   4'h4
`define FCL_OFS_JUMP0  4'h5
`define FCL_OFS_JUMP5  4'hA
`define FCL_OFS_BASEF  4'hB
`define FCL_OFS_BASEV  4'hC
`define FCL_OFS_BASE2  4'hD
`define FCL_OFS_EXTSEL 4'hE
`define FCL_OFS_STATUS 4'hF

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FCL_RST_CEIL   16'h04B0
`define FCL_RST_LOWER  16'h0000
`define FCL_RST_STARTF 16'h0005
`define FCL_RST_JOGF   16'h0032
`define FCL_RST_JUMP   16'h270F
`define FCL_RST_BASEF  16'h01F4
`define FCL_RST_BASEV  16'h22B8
`define FCL_RST_BASE2  16'h270F
`define FCL_RST_EXTSEL 16'h0000
`define FCL_ZERO       16'h0000

// ---------------------------------------------------------------
// ranges and codes
// ---------------------------------------------------------------
`define FCL_F120      16'h04B0
`define FCL_F400      16'h0FA0
`define FCL_V1000     16'h03E8
`define FCL_CODE_OFF  16'h270F
`define FCL_CODE_V95  16'h22B8
`define FCL_CODE_VSUP 16'h270F
`define FCL_PCT95     7'h5F
`define FCL_PCT100    7'h64
`define FCL_NBAND     3

`endif

// File: pkg/fcl_pkg.sv
/*
 * Types of the frequency command limiter.
 * Assumes fcl_cfg.svh is included before this package.
 */
`include "fcl_cfg.svh"
package fcl_pkg;

  typedef logic [`FCL_DW-1:0] fcl_word_t;

  typedef struct packed {
    fcl_word_t            ceil;
    fcl_word_t            lower;
    fcl_word_t            start_f;
    fcl_word_t            jog_f;
    logic [5:0][`FCL_DW-1:0] jump;
    fcl_word_t            base_f;
    fcl_word_t            base_v;
    fcl_word_t            base2;
    fcl_word_t            ext_sel;
    logic [1:0]           sec_sync;
    fcl_word_t            freq_out;
    fcl_word_t            base_out;
    fcl_word_t            vmax_out;
    fcl_word_t            rdata;
  } fcl_state_t;

endpackage

// File: design/fcl_jump_band.sv
/*
 * One jump band: tells whether a frequency lies in the band formed
 * by its A and B settings, and gives the A value as jump point.
 * Assumes settings in 0.1 Hz steps, code 9999 switching it off.
 */
`timescale 1ns/1ps
`include "fcl_cfg.svh"
module fcl_jump_band (
  input  wire logic [`FCL_DW-1:0] a_set,
  input  wire logic [`FCL_DW-1:0] b_set,
  input  wire logic [`FCL_DW-1:0] freq,
  output logic                    hit,
  output logic [`FCL_DW-1:0]      point
);
  logic [`FCL_DW-1:0] lo;
  logic [`FCL_DW-1:0] hi;
  logic               live;

  // a below b: jump at band start; a above b: jump at band end
  assign lo    = (a_set < b_set) ? a_set : b_set;
  assign hi    = (a_set < b_set) ? b_set : a_set;
  assign live  = (a_set != `FCL_CODE_OFF) && (b_set != `FCL_CODE_OFF);
  assign hit   = live && (freq >= lo) && (freq <= hi);
  assign point = a_set;
endmodule

// File: design/fcl_limiter.sv
/*
 * Frequency command limiter: clamps the frequency command, skips up
 * to three jump bands and holds the base frequency and voltage
 * settings of the V/f pattern, all behind a plain register port.
 * Assumes command, ramp and supply inputs on CLK_SYS; the second
 * function input is a pin and is synchronised here.
 */
// Decided for this implementation: the plain strobed port and the address map.
// How it works
// R1 - output clamped to the upper limit; limit 0..120 Hz, reset 120 Hz
// R2 - separate high speed upper limit taking 120..400 Hz
// R3 - writing either upper limit sets both to one shared ceiling
// R4 - lower limit 0..120 Hz, reset 0 Hz
// R5 - output never below lower limit even for lower commands, unless jogging at or below it (R7) or the ceiling is set below the lower limit
// R6 - start alone runs at lower limit when above starting frequency
// R7 - jog at or below lower limit bypasses the lower clamp
// R8 - six jump settings 0..400 Hz or 9999 off, reset 9999
// R9 - three bands from pairs 1A/1B, 2A/2B, 3A/3B
// R10 - steady command inside a band runs at its A value
// R11 - A may be the lower or upper edge of its band
// R12 - while ramping, band frequencies pass through unchanged
// R13 - jump settings writable only while access selection is 0
// R14 - base frequency 0..400 Hz, reset 50 Hz
// R15 - base voltage 0..1000 V, 8888 is 95% supply, 9999 is supply
// R16 - second function input selects second base frequency unless 9999
// R17 - analog input above 50 Hz needs gain frequency raised outside
// R18 - second function input assigned by function code 3 outside
// R19 - maximum output voltage capped at base voltage, never above supply
// R20 - jump substitution first, then lower and upper clamps
`timescale 1ns/1ps
`include "fcl_cfg.svh"
module fcl_limiter (
  input  wire logic              CLK_SYS,
  input  wire logic              SRST,
  input  wire logic              CE,
  input  wire logic [`FCL_AW-1:0] ADDR,
  input  wire logic [`FCL_DW-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [`FCL_DW-1:0] RDATA,
  input  wire logic [`FCL_DW-1:0] CMD_FREQ,
  input  wire logic              CMD_VALID,
  input  wire logic              START,
  input  wire logic              JOG,
  input  wire logic              RAMPING,
  input  wire logic              SECOND_FUNC,
  input  wire logic [`FCL_DW-1:0] SUPPLY_VOLT,
  output logic      [`FCL_DW-1:0] FREQ_OUT,
  output logic      [`FCL_DW-1:0] BASE_FREQ,
  output logic      [`FCL_DW-1:0] VMAX
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fcl_pkg::fcl_state_t st_reg;
  fcl_pkg::fcl_state_t st_next;

  logic [`FCL_NBAND-1:0]         band_hit;
  logic [`FCL_NBAND-1:0][`FCL_DW-1:0] band_pt;
  logic [`FCL_DW-1:0]            src_f;
  logic [`FCL_DW-1:0]            skip_f;
  logic [`FCL_DW-1:0]            clamp_f;
  logic                          jog_low;
  logic                          idle_run;
  logic                          wr_jump;
  logic [2:0]                    jump_idx;
  logic [22:0]                   v95_wide;
  logic [`FCL_DW-1:0]            v95;
  logic [`FCL_DW-1:0]            vmax_f;
  logic [`FCL_DW-1:0]            rd_f;

  // ---------------------------------------------------------------
  // jump bands
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `FCL_NBAND; g = g + 1) begin : g_band
      fcl_jump_band u_band (
        .a_set (st_reg.jump[2*g]),
        .b_set (st_reg.jump[2*g+1]),
        .freq  (src_f),
        .hit   (band_hit[g]),
        .point (band_pt[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // command path
  // ---------------------------------------------------------------
  assign jog_low  = JOG && (st_reg.jog_f <= st_reg.lower);
  assign idle_run = START && (st_reg.lower > st_reg.start_f);

  always_comb begin
    // command source: jog, then the command, then start alone
    if (JOG) begin
      src_f = st_reg.jog_f;
    end else if (CMD_VALID) begin
      src_f = CMD_FREQ;
    end else if (idle_run) begin
      src_f = st_reg.lower; // R6
    end else begin
      src_f = `FCL_ZERO;
    end

    // steady command only; the ramp sweeps straight through
    skip_f = src_f;
    if (!RAMPING) begin // R12
      if (band_hit[0]) begin // R9 R10 R11
        skip_f = band_pt[0];
      end else if (band_hit[1]) begin
        skip_f = band_pt[1];
      end else if (band_hit[2]) begin
        skip_f = band_pt[2];
      end
    end

    // lower clamp first so a crossed pair of limits leaves ceiling
    clamp_f = skip_f; // R20
    if (!jog_low && (clamp_f < st_reg.lower)) begin // R5 R7
      clamp_f = st_reg.lower;
    end
    if (clamp_f > st_reg.ceil) begin // R1
      clamp_f = st_reg.ceil;
    end
  end

  // ---------------------------------------------------------------
  // voltage ceiling
  // ---------------------------------------------------------------
  // widen before the product: 1000 V times 95 overflows 16 bits
  assign v95_wide = (23'(SUPPLY_VOLT) * 23'(`FCL_PCT95)) /
                    23'(`FCL_PCT100);
  assign v95      = v95_wide[`FCL_DW-1:0];

  always_comb begin
    if (st_reg.base_v == `FCL_CODE_V95) begin // R15
      vmax_f = v95;
    end else if (st_reg.base_v == `FCL_CODE_VSUP) begin
      vmax_f = SUPPLY_VOLT;
    end else if (st_reg.base_v < SUPPLY_VOLT) begin // R19
      vmax_f = st_reg.base_v;
    end else begin
      vmax_f = SUPPLY_VOLT;
    end
  end

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  assign wr_jump  = (ADDR >= `FCL_OFS_JUMP0) && (ADDR <= `FCL_OFS_JUMP5);
  assign jump_idx = 3'(ADDR - `FCL_OFS_JUMP0);

  always_comb begin
    case (ADDR)
      `FCL_OFS_UPPER:  rd_f = st_reg.ceil;
      `FCL_OFS_HSUP:   rd_f = st_reg.ceil;
      `FCL_OFS_LOWER:  rd_f = st_reg.lower;
      `FCL_OFS_STARTF: rd_f = st_reg.start_f;
      `FCL_OFS_JOGF:   rd_f = st_reg.jog_f;
      `FCL_OFS_BASEF:  rd_f = st_reg.base_f;
      `FCL_OFS_BASEV:  rd_f = st_reg.base_v;
      `FCL_OFS_BASE2:  rd_f = st_reg.base2;
      `FCL_OFS_EXTSEL: rd_f = st_reg.ext_sel;
      `FCL_OFS_STATUS: rd_f = st_reg.freq_out;
      default: begin
        rd_f = wr_jump ? st_reg.jump[jump_idx] : `FCL_ZERO;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // pin input: two stages before anything reads it
    st_next.sec_sync = {st_reg.sec_sync[0], SECOND_FUNC};
    st_next.freq_out = clamp_f;
    st_next.vmax_out = vmax_f;
    // 9999 in the second setting leaves the normal base in use
    if (st_reg.sec_sync[1] && (st_reg.base2 != `FCL_CODE_OFF)) begin
      st_next.base_out = st_reg.base2; // R16
    end else begin
      st_next.base_out = st_reg.base_f; // R14
    end
    // read data stand only in the cycle after the strobe
    st_next.rdata = RD ? rd_f : `FCL_ZERO;

    // out-of-range writes are dropped, the old setting stays
    if (WR) begin
      case (ADDR)
        `FCL_OFS_UPPER: begin
          if (WDATA <= `FCL_F120) begin // R1 R3
            st_next.ceil = WDATA;
          end
        end
        `FCL_OFS_HSUP: begin
          if ((WDATA >= `FCL_F120) && (WDATA <= `FCL_F400)) begin
            st_next.ceil = WDATA; // R2 R3
          end
        end
        `FCL_OFS_LOWER: begin
          if (WDATA <= `FCL_F120) begin // R4
            st_next.lower = WDATA;
          end
        end
        `FCL_OFS_STARTF: begin
          if (WDATA <= `FCL_F400) begin
            st_next.start_f = WDATA;
          end
        end
        `FCL_OFS_JOGF: begin
          if (WDATA <= `FCL_F400) begin
            st_next.jog_f = WDATA;
          end
        end
        `FCL_OFS_BASEF: begin
          if (WDATA <= `FCL_F400) begin // R14
            st_next.base_f = WDATA;
          end
        end
        `FCL_OFS_BASEV: begin
          if ((WDATA <= `FCL_V1000) || (WDATA == `FCL_CODE_V95) ||
              (WDATA == `FCL_CODE_VSUP)) begin // R15
            st_next.base_v = WDATA;
          end
        end
        `FCL_OFS_BASE2: begin
          if ((WDATA <= `FCL_F400) || (WDATA == `FCL_CODE_OFF)) begin
            st_next.base2 = WDATA; // R16
          end
        end
        `FCL_OFS_EXTSEL: begin
          st_next.ext_sel = WDATA;
        end
        default: begin
          // locked while extended access is selected
          if (wr_jump && (st_reg.ext_sel == `FCL_ZERO) && // R13
              ((WDATA <= `FCL_F400) || (WDATA == `FCL_CODE_OFF))) begin
            st_next.jump[jump_idx] = WDATA; // R8
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_reg.ceil     <= `FCL_RST_CEIL; // R1
      st_reg.lower    <= `FCL_RST_LOWER; // R4
      st_reg.start_f  <= `FCL_RST_STARTF;
      st_reg.jog_f    <= `FCL_RST_JOGF;
      st_reg.jump     <= {6{`FCL_RST_JUMP}}; // R8
      st_reg.base_f   <= `FCL_RST_BASEF; // R14
      st_reg.base_v   <= `FCL_RST_BASEV; // R15
      st_reg.base2    <= `FCL_RST_BASE2; // R16
      st_reg.ext_sel  <= `FCL_RST_EXTSEL;
      st_reg.sec_sync <= 2'h0;
      st_reg.freq_out <= `FCL_ZERO;
      st_reg.base_out <= `FCL_RST_BASEF;
      st_reg.vmax_out <= `FCL_ZERO;
      st_reg.rdata    <= `FCL_ZERO;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign RDATA     = st_reg.rdata;
  assign FREQ_OUT  = st_reg.freq_out;
  assign BASE_FREQ = st_reg.base_out;
  assign VMAX      = st_reg.vmax_out;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  a_ceil_clamp: assert property ( // R1
    CE |=> FREQ_OUT <= $past(st_reg.ceil)
  ) else $error("output above ceiling");

  a_hs_mirror: assert property ( // R3
    CE && WR && (ADDR == `FCL_OFS_HSUP) && (WDATA >= `FCL_F120) &&
    (WDATA <= `FCL_F400) |=> st_reg.ceil == $past(WDATA)
  ) else $error("high speed write not mirrored");

  a_upper_write: assert property ( // R1
    CE && WR && (ADDR == `FCL_OFS_UPPER) && (WDATA > `FCL_F120)
    |=> $stable(st_reg.ceil)
  ) else $error("upper limit took out of range value");

  a_lower_write: assert property ( // R4
    CE && WR && (ADDR == `FCL_OFS_LOWER) && (WDATA > `FCL_F120)
    |=> $stable(st_reg.lower)
  ) else $error("lower limit took out of range value");

  a_jump_range: assert property ( // R8
    CE && WR && wr_jump && (WDATA > `FCL_F400) &&
    (WDATA != `FCL_CODE_OFF) |=> $stable(st_reg.jump)
  ) else $error("jump setting took out of range value");

  a_band_point: assert property ( // R10
    CE && !RAMPING && band_hit[0] && (band_pt[0] >= st_reg.lower) &&
    (band_pt[0] <= st_reg.ceil) |=> FREQ_OUT == $past(band_pt[0])
  ) else $error("steady command in band not at its A value");

  a_lower_floor: assert property ( // R5
    CE && !JOG |=> (FREQ_OUT >= $past(st_reg.lower)) ||
    (FREQ_OUT == $past(st_reg.ceil))
  ) else $error("output below lower limit");

  a_jump_lock: assert property ( // R13
    CE && WR && wr_jump && (st_reg.ext_sel != `FCL_ZERO)
    |=> $stable(st_reg.jump)
  ) else $error("jump setting written while locked");

  a_ramp_pass: assert property ( // R12
    CE && RAMPING && CMD_VALID && !JOG &&
    (CMD_FREQ >= st_reg.lower) && (CMD_FREQ <= st_reg.ceil)
    |=> FREQ_OUT == $past(CMD_FREQ)
  ) else $error("ramp did not pass through");

  a_jog_prec: assert property ( // R7
    CE && jog_low && !RAMPING && (band_hit == 3'h0) &&
    (st_reg.jog_f <= st_reg.ceil) |=> FREQ_OUT == $past(st_reg.jog_f)
  ) else $error("jog clamped by lower limit");

  a_start_run: assert property ( // R6
    CE && START && !CMD_VALID && !JOG &&
    (st_reg.lower > st_reg.start_f) |-> src_f == st_reg.lower
  ) else $error("start alone did not target lower limit");

  a_base_sel: assert property ( // R16
    CE ##1 CE |=> BASE_FREQ == (($past(st_reg.sec_sync[1]) &&
      ($past(st_reg.base2) != `FCL_CODE_OFF)) ?
      $past(st_reg.base2) : $past(st_reg.base_f))
  ) else $error("wrong base frequency selected");

  a_vmax_cap: assert property ( // R19
    CE |=> VMAX <= $past(SUPPLY_VOLT)
  ) else $error("voltage ceiling above supply");

endmodule

// File: testbench/fcl_out_stage.sv
/*
 * Output stage model: ramps its running frequency toward the limited
 * target by a fixed step each cycle.
 * Assumes the target comes straight from the limiter on the same clock.
 */
`timescale 1ns/1ps
`include "fcl_cfg.svh"
module fcl_out_stage #(
  parameter int STEP = 100
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [`FCL_DW-1:0] target,
  output logic      [`FCL_DW-1:0] run_freq
);
  // ramps pass through any band on the way, never skipping
  always_ff @(posedge clk) begin
    if (srst) begin
      run_freq <= 16'h0000;
    end else if (int'(target) - int'(run_freq) > STEP) begin
      run_freq <= run_freq + 16'(STEP);
    end else if (int'(run_freq) - int'(target) > STEP) begin
      run_freq <= run_freq - 16'(STEP);
    end else begin
      run_freq <= target;
    end
  end
endmodule

// File: testbench/testbench.sv
/*
 * Self-checking bench of the frequency command limiter.
 * Assumes fcl_limiter and fcl_out_stage; results checked from queues.
 */
`timescale 1ns/1ps
`include "fcl_cfg.svh"
module testbench;
  logic              clk, srst, wr, rd, cmd_valid, start, jog, ramping;
  logic              sec, chk, rd_d;
  logic [3:0]        addr;
  logic [15:0]       wdata, rdata, cmd, supply, fout, bfreq, vmax, run;
  logic [15:0]       last_f;
  logic [15:0]       sh [16];
  logic [15:0]       q_rd [$];
  logic [47:0]       q_out [$];
  logic [31:0]       lf;
  int                miscompares, n_tests;

  fcl_limiter fcl_limiter_inst (.CLK_SYS(clk), .SRST(srst), .CE(1'b1),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CMD_FREQ(cmd), .CMD_VALID(cmd_valid), .START(start), .JOG(jog),
    .RAMPING(ramping), .SECOND_FUNC(sec), .SUPPLY_VOLT(supply),
    .FREQ_OUT(fout), .BASE_FREQ(bfreq), .VMAX(vmax));
  fcl_out_stage fcl_out_stage_inst (.clk(clk), .srst(srst),
    .target(fout), .run_freq(run));

  // ---------------------------------------------------------------
  // reference and helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // flags f: valid, start, jog, ramping
  function automatic logic [15:0] ref_f(logic [15:0] c, logic [3:0] f);
    logic [15:0] s, a, b, lo, hi;
    logic        hit;
    hit = 1'b0;
    s = f[1] ? sh[4] : f[3] ? c : (f[2] && sh[1] > sh[3]) ? sh[1] : 16'h0;
    for (int i = 0; i < 3; i++) begin
      a = sh[5 + 2 * i];
      b = sh[6 + 2 * i];
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      if (!f[0] && !hit && a != `FCL_CODE_OFF && b != `FCL_CODE_OFF
          && s >= lo && s <= hi) begin
        s = a;
        hit = 1'b1;
      end
    end
    if (!(f[1] && sh[4] <= sh[1]) && s < sh[1]) s = sh[1];
    if (s > sh[0]) s = sh[0];
    return s;
  endfunction

  function automatic logic [15:0] ref_v(logic [15:0] s);
    if (sh[12] == `FCL_CODE_V95) return 16'((32'(s) * 95) / 100);
    if (sh[12] == `FCL_CODE_VSUP) return s;
    return (sh[12] < s) ? sh[12] : s;
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic op(logic w, logic r, logic [3:0] a, logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic idle(int n);
    repeat (n) op(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask

  task automatic cfg(logic [3:0] a, logic [15:0] d);
    op(1'b1, 1'b0, a, d);
    sh[a] = d;
    if (a == `FCL_OFS_UPPER || a == `FCL_OFS_HSUP) begin
      sh[0] = d;
      sh[2] = d;
    end
  endtask

  task automatic rdx(logic [3:0] a, logic [15:0] e);
    q_rd.push_back(e);
    op(1'b0, 1'b1, a, 16'h0000);
  endtask

  task automatic drive(logic [15:0] c, logic [3:0] f, logic [15:0] s);
    cmd <= c;
    {cmd_valid, start, jog, ramping} <= f;
    supply <= s;
    @(posedge clk);
    last_f = ref_f(c, f);
    q_out.push_back({last_f, (sec && sh[13] != `FCL_CODE_OFF) ? sh[13]
                     : sh[11], ref_v(s)});
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask

  task automatic settle(logic [15:0] e);
    int k;
    k = 0;
    while (run !== e && k < 300) begin
      @(posedge clk);
      k++;
    end
    check(run, e);
    if (k >= 300) test_done();
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // monitor: oldest note against each appearing result
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= rd & ~srst;
    if (rd_d) check(rdata, q_rd.pop_front());
    if (chk) begin
      check(fout, q_out[0][47:32]);
      check(bfreq, q_out[0][31:16]);
      check(vmax, q_out[0][15:0]);
      void'(q_out.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] dc [10];
    logic [3:0]  fg [10];
    logic [15:0] jv [6];
    logic [15:0] bv [3];
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0;
    cmd = 16'h0; {cmd_valid, start, jog, ramping} = 4'h0; sec = 1'b0;
    supply = 16'h017C; chk = 1'b0; rd_d = 1'b0; lf = 32'h16927F85;
    miscompares = 0; n_tests = 0; last_f = 16'h0;
    sh = '{`FCL_RST_CEIL, `FCL_RST_LOWER, `FCL_RST_CEIL, `FCL_RST_STARTF,
           `FCL_RST_JOGF, `FCL_RST_JUMP, `FCL_RST_JUMP, `FCL_RST_JUMP,
           `FCL_RST_JUMP, `FCL_RST_JUMP, `FCL_RST_JUMP, `FCL_RST_BASEF,
           `FCL_RST_BASEV, `FCL_RST_BASE2, `FCL_RST_EXTSEL, `FCL_ZERO};
    dc = '{16'h02BC, 16'h0578, 16'h0578, 16'h0320, 16'h0064, 16'h0000,
           16'h0000, 16'h0DAC, 16'h09F6, 16'h0258};
    fg = '{4'h8, 4'h8, 4'h9, 4'h8, 4'h8, 4'h4, 4'h2, 4'h8, 4'h8, 4'h8};
    jv = '{16'h0258, 16'h0320, 16'h05DC, 16'h0514, 16'h09C4, 16'h0A28};
    bv = '{`FCL_CODE_V95, `FCL_CODE_VSUP, 16'h0190};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 16; a++) rdx(4'(a), sh[a]);
    idle(2);
    $display("test reset values done");
    cfg(`FCL_OFS_HSUP, 16'h0BB8);
    rdx(`FCL_OFS_UPPER, 16'h0BB8);
    cfg(`FCL_OFS_UPPER, 16'h044C);
    rdx(`FCL_OFS_HSUP, 16'h044C);
    op(1'b1, 1'b0, `FCL_OFS_HSUP, 16'h03E8);
    rdx(`FCL_OFS_UPPER, 16'h044C);
    op(1'b1, 1'b0, `FCL_OFS_UPPER, 16'h04B1);
    rdx(`FCL_OFS_HSUP, 16'h044C);
    op(1'b1, 1'b0, `FCL_OFS_LOWER, 16'h04B1);
    rdx(`FCL_OFS_LOWER, 16'h0000);
    cfg(`FCL_OFS_EXTSEL, 16'h0001);
    op(1'b1, 1'b0, `FCL_OFS_JUMP0, 16'h0258);
    rdx(`FCL_OFS_JUMP0, `FCL_CODE_OFF);
    cfg(`FCL_OFS_EXTSEL, 16'h0000);
    op(1'b1, 1'b0, `FCL_OFS_JUMP5, 16'h0FA1);
    rdx(`FCL_OFS_JUMP5, `FCL_CODE_OFF);
    op(1'b1, 1'b0, `FCL_OFS_BASEV, 16'h03E9);
    rdx(`FCL_OFS_BASEV, `FCL_CODE_V95);
    op(1'b1, 1'b0, `FCL_OFS_STATUS, 16'h0123);
    rdx(`FCL_OFS_STATUS, 16'h0000);
    cfg(`FCL_OFS_HSUP, 16'h0BB8);
    cfg(`FCL_OFS_LOWER, 16'h00C8);
    cfg(`FCL_OFS_JOGF, 16'h0064);
    for (int i = 0; i < 6; i++) cfg(4'(`FCL_OFS_JUMP0 + i), jv[i]);
    idle(2);
    $display("test register access done");
    // bands, clamps, start alone, jog and ramp bypass
    // commands above 50 Hz arrive already scaled by a raised gain
    for (int i = 0; i < 10; i++) drive(dc[i], fg[i], 16'h017C);
    settle(last_f);
    rdx(`FCL_OFS_STATUS, last_f);
    idle(2);
    $display("test frequency path done");
    for (int i = 0; i < 3; i++) begin
      cfg(`FCL_OFS_BASEV, bv[i]);
      idle(1);
      drive(16'h0000, 4'h0, 16'h017C);
      drive(16'h0000, 4'h0, 16'h01A4);
    end
    sec <= 1'b1;
    idle(4);
    drive(16'h0000, 4'h0, 16'h017C);
    cfg(`FCL_OFS_BASE2, 16'h0258);
    idle(1);
    drive(16'h0000, 4'h0, 16'h017C);
    cfg(`FCL_OFS_BASEF, 16'h02BC);
    sec <= 1'b0;
    idle(4);
    drive(16'h0000, 4'h0, 16'h017C);
    $display("test voltage and base done");
    for (int i = 0; i < 80; i++) begin
      lf = nxt(lf);
      drive(16'(lf[15:0] % 4001), {lf[16], lf[17], lf[18] & lf[19],
            lf[20]}, 16'(lf[31:22] % 1001));
    end
    idle(3);
    $display("test random commands done");
    test_done();
  end
endmodule
